// [logic/ccr_pkg.sv]
// Package with register map, field layout, reset values and timing for the charger config bank.
package ccr_pkg;

    // ------------------------------------------------------------------
    // Register indices and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] IDX_VOLTAGE      = 2'h0;
    localparam logic [1:0] IDX_TERM_TIMER   = 2'h1;
    localparam logic [1:0] IDX_COMP_THERMAL = 2'h2;
    localparam logic [7:0] RST_VOLTAGE      = 8'h5E;
    localparam logic [7:0] RST_TERM_TIMER   = 8'h9D;
    localparam logic [7:0] RST_COMP_THERMAL = 8'h03;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int VLIM_LSB      = 2;
    localparam int PRECHG_BIT    = 1;
    localparam int RECHG_BIT     = 0;
    localparam int TERM_EN_BIT   = 7;
    localparam int STAT_OFF_BIT  = 6;
    localparam int WDOG_LSB      = 4;
    localparam int SAFETY_EN_BIT = 3;
    localparam int FCT_LSB       = 1;
    localparam int COLD_BIT      = 0;
    localparam int IRR_LSB       = 5;
    localparam int IRC_LSB       = 2;
    localparam int THERM_LSB     = 0;

    // Highest charge voltage code applied; higher codes clamp here.
    localparam logic [5:0] VLIM_MAX_CODE = 6'h30;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam longint CLK_HZ       = 125000000;
    localparam longint WDOG_BASE_S  = 40;
    localparam longint WDOG_BASE_CY = WDOG_BASE_S * CLK_HZ;

    typedef enum logic [1:0] {
        CCR_WD_OFF,
        CCR_WD_40S,
        CCR_WD_80S,
        CCR_WD_160S
    } ccr_wdog_e;

endpackage : ccr_pkg

// [logic/ccr_wdog_if.sv]
// Interface between the register bank and its host watchdog timer.
`timescale 1ns/1ps
interface ccr_wdog_if;
    logic [1:0] sel;
    logic       kick;
    logic       expire;
    modport bank (output sel, output kick, input expire);
    modport timer (input sel, input kick, output expire);
endinterface : ccr_wdog_if

// [logic/ccr_wdog.sv]
// Host watchdog timer that expires when the host stops restarting it.
`timescale 1ns/1ps
module ccr_wdog #(
    parameter longint BASE_CYCLES = ccr_pkg::WDOG_BASE_CY
) (
    input  wire logic   mclk,
    input  wire logic   rst_n,
    ccr_wdog_if.timer   wd
);
    logic [39:0] count;
    logic [39:0] limit;
    logic        hit;

    // Limit is 1x, 2x or 4x the base period; code zero never expires.
    assign limit = (wd.sel == 2'h3) ? 40'(BASE_CYCLES * 4) :
                   (wd.sel == 2'h2) ? 40'(BASE_CYCLES * 2) : 40'(BASE_CYCLES);
    assign hit   = (wd.sel != 2'h0) && (count >= limit - 40'h1);

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // timeout counting
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count     <= 40'h0;
            wd.expire <= 1'b0;
        end else begin
            wd.expire <= hit && !wd.kick;
            if (wd.kick || hit || wd.sel == 2'h0) begin
                count <= 40'h0;
            end else begin
                count <= count + 40'h1;
            end
        end
    end
endmodule : ccr_wdog

// [logic/ccr_regs.sv]
// Charger configuration register bank with clamping and watchdog defaults.
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/1ps
module ccr_regs #(
    parameter longint WDOG_BASE_CYCLES = ccr_pkg::WDOG_BASE_CY
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    input  wire logic [1:0] addr,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata,
    input  wire logic       reg_reset,
    input  wire logic       host_timer_kick,
    output logic      [5:0] charge_voltage_limit,
    output logic            precharge_threshold_sel,
    output logic            recharge_offset_sel,
    output logic            term_enable,
    output logic            status_pin_disable,
    output logic      [1:0] wdog_timeout_sel,
    output logic            safety_timer_enable,
    output logic      [1:0] fast_charge_timer_sel,
    output logic            cold_current_scale_sel,
    output logic      [2:0] ir_comp_resistance,
    output logic      [2:0] ir_comp_clamp,
    output logic      [1:0] thermal_reg_threshold,
    output logic            wdog_expired
);
    logic [7:0] charge_voltage_thresholds;
    logic [7:0] termination_timer_control;
    logic [7:0] compensation_thermal_control;
    logic [7:0] next_rdata;
    logic [5:0] raw_vlim;
    logic       to_default;
    logic       hit_voltage;
    logic       hit_term;
    logic       hit_comp;

    ccr_wdog_if wd ();

    // ------------------------------------------------------------------
    // Watchdog timer
    // ------------------------------------------------------------------
    // kick restarts timer
    assign wd.kick = host_timer_kick;
    assign wd.sel  = termination_timer_control[ccr_pkg::WDOG_LSB +: 2];

    ccr_wdog #(
        .BASE_CYCLES (WDOG_BASE_CYCLES)
    ) u_wdog (
        .mclk  (mclk),
        .rst_n (rst_n),
        .wd    (wd.timer)
    );

    assign to_default = reg_reset || wd.expire;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // One compare per register, shared by the write path and the read mux.
    assign hit_voltage = (addr == ccr_pkg::IDX_VOLTAGE);
    assign hit_term    = (addr == ccr_pkg::IDX_TERM_TIMER);
    assign hit_comp    = (addr == ccr_pkg::IDX_COMP_THERMAL);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    // A restore beats a write in the same cycle, so expiry always wins.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            charge_voltage_thresholds    <= ccr_pkg::RST_VOLTAGE;
            termination_timer_control    <= ccr_pkg::RST_TERM_TIMER;
            compensation_thermal_control <= ccr_pkg::RST_COMP_THERMAL;
        end else if (to_default) begin
            charge_voltage_thresholds    <= ccr_pkg::RST_VOLTAGE;
            termination_timer_control    <= ccr_pkg::RST_TERM_TIMER;
            compensation_thermal_control <= ccr_pkg::RST_COMP_THERMAL;
        end else if (wr_en) begin
            if (hit_voltage) charge_voltage_thresholds <= wdata;
            if (hit_term) termination_timer_control <= wdata;
            if (hit_comp) compensation_thermal_control <= wdata;
        end
    end

    // ------------------------------------------------------------------
    // Readback
    // ------------------------------------------------------------------
    // Stored value is returned; clamping only affects the applied limit.
    assign next_rdata = hit_voltage ? charge_voltage_thresholds :
                        hit_term    ? termination_timer_control :
                        hit_comp    ? compensation_thermal_control :
                                      8'h00;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd_en) begin
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    // voltage limit field
    assign raw_vlim = charge_voltage_thresholds[ccr_pkg::VLIM_LSB +: 6];
    assign charge_voltage_limit = (raw_vlim > ccr_pkg::VLIM_MAX_CODE) ?
                                  ccr_pkg::VLIM_MAX_CODE : raw_vlim;
    assign precharge_threshold_sel = charge_voltage_thresholds[ccr_pkg::PRECHG_BIT];
    assign recharge_offset_sel     = charge_voltage_thresholds[ccr_pkg::RECHG_BIT];
    assign term_enable             = termination_timer_control[ccr_pkg::TERM_EN_BIT];
    assign status_pin_disable      = termination_timer_control[ccr_pkg::STAT_OFF_BIT];
    assign wdog_timeout_sel        = termination_timer_control[ccr_pkg::WDOG_LSB +: 2];
    assign safety_timer_enable     = termination_timer_control[ccr_pkg::SAFETY_EN_BIT];
    assign fast_charge_timer_sel   = termination_timer_control[ccr_pkg::FCT_LSB +: 2];
    assign cold_current_scale_sel  = termination_timer_control[ccr_pkg::COLD_BIT];
    assign ir_comp_resistance      = compensation_thermal_control[ccr_pkg::IRR_LSB +: 3];
    assign ir_comp_clamp           = compensation_thermal_control[ccr_pkg::IRC_LSB +: 3];
    assign thermal_reg_threshold   = compensation_thermal_control[ccr_pkg::THERM_LSB +: 2];
    assign wdog_expired            = wd.expire;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_vlim_clamp: assert property (@(posedge mclk) disable iff (!rst_n)
        charge_voltage_limit <= ccr_pkg::VLIM_MAX_CODE)
        else $error("applied voltage code above clamp");
    a_vlim_pass: assert property (@(posedge mclk) disable iff (!rst_n)
        (raw_vlim <= ccr_pkg::VLIM_MAX_CODE) |-> charge_voltage_limit == raw_vlim)
        else $error("legal voltage code altered");
    a_default_restore: assert property (@(posedge mclk) disable iff (!rst_n)
        to_default |=> (charge_voltage_thresholds == ccr_pkg::RST_VOLTAGE &&
        termination_timer_control == ccr_pkg::RST_TERM_TIMER &&
        compensation_thermal_control == ccr_pkg::RST_COMP_THERMAL))
        else $error("defaults not restored");
    a_write_takes: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_en && !to_default && addr == ccr_pkg::IDX_TERM_TIMER) |=>
        term_enable == $past(wdata[ccr_pkg::TERM_EN_BIT]))
        else $error("termination enable write lost");
    a_wdog_off: assert property (@(posedge mclk) disable iff (!rst_n)
        (wdog_timeout_sel == 2'h0) |=> !wd.expire)
        else $error("disabled watchdog expired");
    a_kick_holds: assert property (@(posedge mclk) disable iff (!rst_n)
        host_timer_kick |=> !wd.expire)
        else $error("expiry right after kick");
    a_fct_write: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_en && !to_default && addr == ccr_pkg::IDX_TERM_TIMER) |=>
        fast_charge_timer_sel == $past(wdata[2:1]))
        else $error("fast charge timer write lost");
    a_comp_write: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_en && !to_default && addr == ccr_pkg::IDX_COMP_THERMAL) |=>
        ir_comp_resistance == $past(wdata[7:5]) && ir_comp_clamp == $past(wdata[4:2]))
        else $error("compensation write lost");

    // ------------------------------------------------------------------
    // Field write checks
    // ------------------------------------------------------------------
    // Each field must follow its own bits of the byte written a cycle earlier; an oversized voltage code must apply as the clamp.
    a_prechg_write: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_en && !to_default && hit_voltage) |=>
        precharge_threshold_sel == $past(wdata[ccr_pkg::PRECHG_BIT]))
        else $error("precharge threshold write lost");
    a_rechg_write: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_en && !to_default && hit_voltage) |=>
        recharge_offset_sel == $past(wdata[ccr_pkg::RECHG_BIT]))
        else $error("recharge offset write lost");
    a_vlim_write: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_en && !to_default && hit_voltage &&
        wdata[ccr_pkg::VLIM_LSB +: 6] > ccr_pkg::VLIM_MAX_CODE) |=>
        charge_voltage_limit == ccr_pkg::VLIM_MAX_CODE)
        else $error("oversized voltage code not clamped");
    a_stat_write: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_en && !to_default && hit_term) |=>
        status_pin_disable == $past(wdata[ccr_pkg::STAT_OFF_BIT]))
        else $error("status pin disable write lost");
    a_safety_write: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_en && !to_default && hit_term) |=>
        safety_timer_enable == $past(wdata[ccr_pkg::SAFETY_EN_BIT]))
        else $error("safety timer enable write lost");
    a_cold_write: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_en && !to_default && hit_term) |=>
        cold_current_scale_sel == $past(wdata[ccr_pkg::COLD_BIT]))
        else $error("cold current scale write lost");
    a_clamp_write: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_en && !to_default && hit_comp) |=>
        ir_comp_clamp == $past(wdata[ccr_pkg::IRC_LSB +: 3]))
        else $error("compensation clamp write lost");

    // Settings move only on a write or a restore; any other change would
    // silently retune the charger behind the host's back.
    a_fields_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        (!wr_en && !to_default) |=>
        $stable(charge_voltage_thresholds) && $stable(termination_timer_control) &&
        $stable(compensation_thermal_control))
        else $error("register changed without write or restore");

    // Expiry is a single-cycle event; a stuck flag would pin the bank at defaults.
    // This needs a base period of at least two cycles.
    a_expire_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
        wd.expire |=> !wd.expire)
        else $error("watchdog expiry held longer than one cycle");
endmodule : ccr_regs

// [verification/ccr_host.sv]
// Host model that reaches the charger register bank one access at a time.
`timescale 1ns/1ps
module ccr_host (
    input  wire logic       mclk,
    output logic            wr_en,
    output logic            rd_en,
    output logic      [1:0] addr,
    output logic      [7:0] wdata,
    output logic            reg_reset,
    output logic            host_timer_kick,
    input  wire logic [7:0] rdata
);
    // All strobes idle low from time zero.
    initial begin
        {wr_en, rd_en, addr, wdata, reg_reset, host_timer_kick} = '0;
    end
    // One access held over one rising edge; idle lines then show the inverse.
    // every access also restarts the watchdog
    task automatic op(input logic w, input logic [1:0] a, input logic [7:0] d,
                      output logic [7:0] q);
        @(negedge mclk);
        {wr_en, rd_en, addr, wdata, host_timer_kick} = {w, !w, a, d, 1'b1};
        @(negedge mclk);
        q = rdata;
        {wr_en, rd_en, host_timer_kick} = '0;
        {addr, wdata} = ~{a, d};
    endtask : op
    // Register-reset command, one cycle long.
    task automatic restore();
        @(negedge mclk);
        reg_reset = 1'b1;
        @(negedge mclk);
        reg_reset = 1'b0;
    endtask : restore
endmodule : ccr_host

// [verification/testbench.sv]
// Self-checking bench for the charger configuration register bank.
`timescale 1ns/1ps
module testbench;
    localparam longint BASE = 50;
    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    logic       wr_en, rd_en, reg_reset, kick, pre, rech, term, stat, safe, cold, expd;
    logic [1:0] addr, wsel, fct, thr;
    logic [2:0] irr, irc;
    logic [5:0] cvl;
    logic [7:0] wdata, rdata, q;
    logic [7:0] exp_r [3];
    wire [23:0] flds = {cvl, pre, rech, term, stat, wsel, safe, fct, cold, irr, irc, thr};
    int         fails = 0;
    int         compares = 0;
    int         n;
    int         m;

    // 125 MHz clock.
    always #4 mclk = ~mclk;

    ccr_host h (.mclk(mclk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
                .reg_reset(reg_reset), .host_timer_kick(kick), .rdata(rdata));
    ccr_regs #(.WDOG_BASE_CYCLES(BASE)) dut (.mclk(mclk), .rst_n(rst_n), .wr_en(wr_en),
        .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata), .reg_reset(reg_reset),
        .host_timer_kick(kick), .charge_voltage_limit(cvl), .precharge_threshold_sel(pre),
        .recharge_offset_sel(rech), .term_enable(term), .status_pin_disable(stat),
        .wdog_timeout_sel(wsel), .safety_timer_enable(safe), .fast_charge_timer_sel(fct),
        .cold_current_scale_sel(cold), .ir_comp_resistance(irr), .ir_comp_clamp(irc),
        .thermal_reg_threshold(thr), .wdog_expired(expd));

    // ------------------------------------------------------------------
    // Expectation and reporting helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [23:0] got, input logic [23:0] want);
        compares++;
        if (got !== want) begin
            fails++;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
        end
    endtask : chk
    // Applied voltage code saturates; the other fields pass straight through.
    function automatic logic [23:0] want_f();
        logic [5:0] v;
        v = (exp_r[0][7:2] > 6'h30) ? 6'h30 : exp_r[0][7:2];
        return {v, exp_r[0][1:0], exp_r[1], exp_r[2]};
    endfunction : want_f
    task automatic defaults();
        exp_r = '{8'h5E, 8'h9D, 8'h03};
    endtask : defaults
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        h.op(1'b1, a, d, q);
        if (a != 2'h3) exp_r[a] = d;
    endtask : wr
    // Reads every index, the unmapped one included, then checks the fields.
    task automatic rd_all();
        for (int i = 0; i < 4; i++) begin
            h.op(1'b0, 2'(i), 8'($urandom), q);
            chk(24'(q), (i < 3) ? 24'(exp_r[i]) : 24'h0);
        end
        chk(flds, want_f());
    endtask : rd_all
    // Counts idle cycles until expiry, bounded by hi.
    task automatic wait_exp(input int hi);
        n = 0;
        while (expd !== 1'b1 && n <= hi) begin
            @(negedge mclk);
            n++;
        end
    endtask : wait_exp
    task automatic wrap_up();
        if (fails == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'hCB319D24));
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        defaults();
        rd_all();
        for (int i = 0; i < 8; i++) begin
            wr(2'h0, 8'hBC + 8'(i << 2));
            chk(flds, want_f());
        end
        wr(2'h3, 8'h55);
        rd_all();
        // Walk every code of the multi-bit fields in the timer and compensation registers, then random traffic.
        for (int i = 0; i < 8; i++) begin
            wr(2'h2, {3'(i), 3'(7 - i), 2'(i)});
            wr(2'h1, {2'(i), 2'(i), 1'(i), 2'(i), 1'(i >> 1)});
            chk(flds, want_f());
        end
        repeat (40) begin
            wr(2'($urandom_range(3)), 8'($urandom));
            chk(flds, want_f());
        end
        rd_all();
        // Reset in mid-run: registers and the read port return to their reset state.
        @(negedge mclk);
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        defaults();
        chk(24'(rdata), 24'h0);
        chk(flds, want_f());
        rd_all();
        h.restore();
        defaults();
        rd_all();
        // Each nonzero timeout setting expires after its multiple of the base period; setting zero never expires.
        for (int s = 1; s < 4; s++) begin
            wr(2'h0, 8'h33);
            wr(2'h1, {2'h1, 2'(s), 4'h6});
            wait_exp(int'(BASE) * 4 + 3);
            m = int'(BASE) << (s - 1);
            chk(24'(n >= m - 3 && n <= m + 3), 24'h1);
            if (n > int'(BASE) * 4 + 3) wrap_up();
            @(negedge mclk);
            defaults();
            rd_all();
        end
        wr(2'h1, 8'h8D);
        wait_exp(int'(BASE) * 5);
        chk(24'(n > int'(BASE) * 5), 24'h1);
        wrap_up();
    end
endmodule : testbench
